// ### core/spoo_six_phase_output.sv
// Module: six-phase PWM output selection stage with software override and Wishbone register slave
//
// The register offsets and register access over Wishbone were left to the implementer.

// Notes on behaviour
// RL1 - V value 0: V positive inactive; V negative active unless polarity inverts it.
// RL2 - V value 1: V positive active; V negative inactive unless polarity bit is 1.
// RL3 - W value at bit 0 maps onto the W pair exactly like V.
// RL4 - Software W value changes pass through dead-time insertion like timer edges.
// RL5 - Each phase comes from the compare flip-flop or the software value, by select.
// RL6 - Software output, when selected, wins over timer output on all six pins.
// RL7 - After select clears with timer running, software levels hold until next compare event.
// RL8 - Select cleared while count enable is 0 stops driving all six pins.
// RL9 - Selecting software with U value 0 takes U positive low at next update point; the code drives it inactive, high when active level is 0.
// RL10 - Output enable 0 puts pins in high impedance regardless of other bits.
// RL11 - Enabled: idle when select and count enable 0, else timer or software output.
// RL12 - Pin enable at bit 0; select bit 7, U value bit 2 of software register.
// RL13 - Count enable sits at bit 15 of the timer control register.
// RL14 - Mode register: active level bit 7, U/V/W negative polarity bits 6/5/4.
// RL15 - Select 0 means timer output, 1 software; writes to values move the pins.
// RL16 - U value maps to the U pair like V, with its own polarity bit.
// RL17 - After reset select, values and enable are 0: pins float, timer selected.
module spoo_six_phase_output
   import spoo_pkg::*;
(
   input wire logic sys_clk, // Timer base clock
   input wire logic rst_n, // Asynchronous reset, active low
   input wire logic wb_cyc_i, // Wishbone cycle
   input wire logic wb_stb_i, // Wishbone strobe
   input wire logic wb_we_i, // Wishbone write enable
   input wire logic [spoo_pkg::SPOO_ADR_W-1:0] wb_adr_i, // Wishbone byte address
   input wire logic [3:0] wb_sel_i, // Wishbone byte selects
   input wire logic [spoo_pkg::SPOO_DAT_W-1:0] wb_dat_i, // Wishbone write data
   output logic [spoo_pkg::SPOO_DAT_W-1:0] wb_dat_o, // Wishbone read data
   output logic wb_ack_o, // Wishbone acknowledge
   input wire logic [2:0] cmp_set, // Compare-match set pulses, U/V/W in bits 2/1/0
   input wire logic [2:0] cmp_reset, // Compare-match reset pulses, U/V/W in bits 2/1/0
   output logic count_enable, // Count enable to the up/down counter
   output logic u_pos_out, // U positive pin level
   output logic u_pos_oe, // U positive pin drive enable
   output logic u_neg_out, // U negative pin level
   output logic u_neg_oe, // U negative pin drive enable
   output logic v_pos_out, // V positive pin level
   output logic v_pos_oe, // V positive pin drive enable
   output logic v_neg_out, // V negative pin level
   output logic v_neg_oe, // V negative pin drive enable
   output logic w_pos_out, // W positive pin level
   output logic w_pos_oe, // W positive pin drive enable
   output logic w_neg_out, // W negative pin level
   output logic w_neg_oe // W negative pin drive enable
);
   import spoo_pkg::*;

   // ----------------------------------------------------------------
   // Decoding helpers
   // ----------------------------------------------------------------
   function automatic logic spoo_hit(input logic [SPOO_ADR_W-1:0] adr, input logic [7:0] ofs);
      spoo_hit = (adr[7:2] == ofs[7:2]);
   endfunction : spoo_hit

   // Pair levels: positive follows the phase, negative is its complement unless polarity is set
   function automatic logic [1:0] spoo_pair(input logic ph, input logic act, input logic pol);
      logic pos;
      pos = ph ? act : ~act;
      spoo_pair = {pol ? pos : ~pos, pos};
   endfunction : spoo_pair

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   logic sw_output_select;
   logic [2:0] sw_value; // U/V/W in bits 2/1/0
   logic active_level;
   logic [2:0] neg_polarity; // U/V/W in bits 2/1/0
   logic pin_output_enable;
   logic [SPOO_DEAD_W-1:0] dead_time;
   logic [2:0] phase_ff;
   logic [5:0] pin_lvl;
   logic [5:0] pin_en;
   logic bus_req;
   logic wr_en;
   logic [SPOO_DAT_W-1:0] next_rdata;

   assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign wr_en = bus_req & wb_we_i;

   // ----------------------------------------------------------------
   // Bus acknowledge: one wait state, every address answered
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= bus_req;
      end
   end

   // ----------------------------------------------------------------
   // Software phase register
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         sw_output_select <= SPOO_RST_SW_PHASE[SPOO_BIT_SW_SEL]; // [RL17]
         sw_value <= SPOO_RST_SW_PHASE[2:0]; // [RL17]
      end else if (wr_en && spoo_hit(wb_adr_i, SPOO_OFS_SW_PHASE) && wb_sel_i[0]) begin
         sw_output_select <= wb_dat_i[SPOO_BIT_SW_SEL]; // [RL12] [RL15]
         sw_value[2] <= wb_dat_i[SPOO_BIT_U_SW]; // [RL12]
         sw_value[1] <= wb_dat_i[SPOO_BIT_V_SW];
         sw_value[0] <= wb_dat_i[SPOO_BIT_W_SW]; // [RL3]
      end
   end

   // ----------------------------------------------------------------
   // Output mode register
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         active_level <= SPOO_RST_MODE[3];
         neg_polarity <= SPOO_RST_MODE[2:0];
      end else if (wr_en && spoo_hit(wb_adr_i, SPOO_OFS_MODE) && wb_sel_i[0]) begin
         active_level <= wb_dat_i[SPOO_BIT_ACT_LVL]; // [RL14]
         neg_polarity[2] <= wb_dat_i[SPOO_BIT_U_POL]; // [RL14]
         neg_polarity[1] <= wb_dat_i[SPOO_BIT_V_POL];
         neg_polarity[0] <= wb_dat_i[SPOO_BIT_W_POL];
      end
   end

   // ----------------------------------------------------------------
   // Output enable and timer control registers
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_output_enable <= SPOO_RST_OE; // [RL17]
      end else if (wr_en && spoo_hit(wb_adr_i, SPOO_OFS_OE) && wb_sel_i[0]) begin
         pin_output_enable <= wb_dat_i[SPOO_BIT_PIN_OE]; // [RL12]
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         count_enable <= SPOO_RST_CNT_EN;
      end else if (wr_en && spoo_hit(wb_adr_i, SPOO_OFS_TCTL) && wb_sel_i[1]) begin
         count_enable <= wb_dat_i[SPOO_BIT_CNT_EN]; // [RL13]
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         dead_time <= SPOO_RST_DEAD;
      end else if (wr_en && spoo_hit(wb_adr_i, SPOO_OFS_DEAD) && wb_sel_i[0]) begin
         dead_time <= wb_dat_i[SPOO_DEAD_W-1:0];
      end
   end

   // ----------------------------------------------------------------
   // Read data
   // ----------------------------------------------------------------
   always_comb begin
      next_rdata = '0;
      if (spoo_hit(wb_adr_i, SPOO_OFS_SW_PHASE)) begin
         next_rdata[SPOO_BIT_SW_SEL] = sw_output_select;
         next_rdata[SPOO_BIT_U_SW] = sw_value[2];
         next_rdata[SPOO_BIT_V_SW] = sw_value[1];
         next_rdata[SPOO_BIT_W_SW] = sw_value[0];
      end else if (spoo_hit(wb_adr_i, SPOO_OFS_MODE)) begin
         next_rdata[SPOO_BIT_ACT_LVL] = active_level;
         next_rdata[SPOO_BIT_U_POL] = neg_polarity[2];
         next_rdata[SPOO_BIT_V_POL] = neg_polarity[1];
         next_rdata[SPOO_BIT_W_POL] = neg_polarity[0];
      end else if (spoo_hit(wb_adr_i, SPOO_OFS_OE)) begin
         next_rdata[SPOO_BIT_PIN_OE] = pin_output_enable;
      end else if (spoo_hit(wb_adr_i, SPOO_OFS_TCTL)) begin
         next_rdata[SPOO_BIT_CNT_EN] = count_enable;
      end else if (spoo_hit(wb_adr_i, SPOO_OFS_DEAD)) begin
         next_rdata[SPOO_DEAD_W-1:0] = dead_time;
      end else if (spoo_hit(wb_adr_i, SPOO_OFS_STAT)) begin
         next_rdata[SPOO_STAT_LVL_LSB +: 6] = pin_lvl;
         next_rdata[SPOO_STAT_EN_LSB +: 6] = pin_en;
         next_rdata[SPOO_STAT_FF_LSB +: 3] = phase_ff;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         wb_dat_o <= '0;
      end else if (bus_req && !wb_we_i) begin
         wb_dat_o <= next_rdata;
      end
   end

   // ----------------------------------------------------------------
   // Per-phase output path
   // ----------------------------------------------------------------
   genvar p;
   generate
      for (p = 0; p < SPOO_PHASES; p++) begin : g_phase
         logic [SPOO_DEAD_W:0] dead_cnt;
         logic ff_prev;
         logic [1:0] lvl;

         // Phase flip-flop: software value overrides; otherwise only compare events move it,
         // so levels left by software stay until the first set or reset after select clears
         always_ff @(posedge sys_clk or negedge rst_n) begin
            if (!rst_n) begin
               phase_ff[p] <= 1'b0;
            end else if (sw_output_select) begin
               phase_ff[p] <= sw_value[p]; // [RL5] [RL6] [RL9] [RL15]
            end else if (cmp_set[p]) begin
               phase_ff[p] <= 1'b1; // [RL5] [RL7]
            end else if (cmp_reset[p]) begin
               phase_ff[p] <= 1'b0; // [RL7]
            end
         end

         // Dead time: every edge of the phase, software or timer, parks both pins inactive
         // for dead_time+2 cycles before the new level is let through
         always_ff @(posedge sys_clk or negedge rst_n) begin
            if (!rst_n) begin
               ff_prev <= 1'b0;
               dead_cnt <= '0;
            end else begin
               ff_prev <= phase_ff[p];
               if (ff_prev != phase_ff[p]) begin
                  dead_cnt <= {1'b0, dead_time} + 1'b1; // [RL4]
               end else if (dead_cnt != '0) begin
                  dead_cnt <= dead_cnt - 1'b1;
               end
            end
         end

         always_comb begin
            lvl = spoo_pair(phase_ff[p], active_level, neg_polarity[p]); // [RL1] [RL2] [RL3] [RL16]
            if ((ff_prev != phase_ff[p]) || (dead_cnt != '0)) begin
               lvl = {~active_level, ~active_level}; // [RL4]
            end
         end

         always_ff @(posedge sys_clk or negedge rst_n) begin
            if (!rst_n) begin
               pin_lvl[2*p +: 2] <= 2'h0;
               pin_en[2*p +: 2] <= 2'h0;
            end else begin
               pin_lvl[2*p +: 2] <= lvl;
               // Drive only when enabled and either software or the running timer owns the pin
               pin_en[2*p +: 2] <= {2{pin_output_enable & (sw_output_select | count_enable)}}; // [RL8] [RL10] [RL11]
            end
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // Pin outputs: pair index 0 is W, 1 is V, 2 is U
   // ----------------------------------------------------------------
   assign w_pos_out = pin_lvl[0];
   assign w_neg_out = pin_lvl[1];
   assign v_pos_out = pin_lvl[2];
   assign v_neg_out = pin_lvl[3];
   assign u_pos_out = pin_lvl[4];
   assign u_neg_out = pin_lvl[5];
   assign w_pos_oe = pin_en[0];
   assign w_neg_oe = pin_en[1];
   assign v_pos_oe = pin_en[2];
   assign v_neg_oe = pin_en[3];
   assign u_pos_oe = pin_en[4];
   assign u_neg_oe = pin_en[5];

endmodule : spoo_six_phase_output

// ### core/spoo_pkg.sv
// Package: register map, field positions, reset values and widths of the six-phase output stage
package spoo_pkg;

   // ----------------------------------------------------------------
   // Bus geometry
   // ----------------------------------------------------------------
   localparam int SPOO_ADR_W = 8;
   localparam int SPOO_DAT_W = 32;

   // ----------------------------------------------------------------
   // Register byte offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] SPOO_OFS_SW_PHASE = 8'h00;
   localparam logic [7:0] SPOO_OFS_MODE = 8'h04;
   localparam logic [7:0] SPOO_OFS_OE = 8'h08;
   localparam logic [7:0] SPOO_OFS_TCTL = 8'h0c;
   localparam logic [7:0] SPOO_OFS_DEAD = 8'h10;
   localparam logic [7:0] SPOO_OFS_STAT = 8'h14;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int SPOO_BIT_SW_SEL = 7;
   localparam int SPOO_BIT_U_SW = 2;
   localparam int SPOO_BIT_V_SW = 1;
   localparam int SPOO_BIT_W_SW = 0;
   localparam int SPOO_BIT_ACT_LVL = 7;
   localparam int SPOO_BIT_U_POL = 6;
   localparam int SPOO_BIT_V_POL = 5;
   localparam int SPOO_BIT_W_POL = 4;
   localparam int SPOO_BIT_PIN_OE = 0;
   localparam int SPOO_BIT_CNT_EN = 15;
   localparam int SPOO_STAT_LVL_LSB = 0;
   localparam int SPOO_STAT_EN_LSB = 6;
   localparam int SPOO_STAT_FF_LSB = 12;

   // ----------------------------------------------------------------
   // Reset values and widths
   // ----------------------------------------------------------------
   localparam logic [7:0] SPOO_RST_SW_PHASE = 8'h00;
   localparam logic [3:0] SPOO_RST_MODE = 4'h0;
   localparam logic SPOO_RST_OE = 1'b0;
   localparam logic SPOO_RST_CNT_EN = 1'b0;
   localparam int SPOO_DEAD_W = 8;
   localparam logic [7:0] SPOO_RST_DEAD = 8'h00;
   localparam int SPOO_PHASES = 3;

endpackage : spoo_pkg

// ### verification/spoo_chk_sva.sv
// Checker: bus handshake and pin-level assertions for the six-phase output stage
module spoo_chk
   import spoo_pkg::*;
(
   input wire logic sys_clk, // Clock
   input wire logic rst_n, // Reset, active low
   input wire logic wb_cyc_i, // Bus cycle
   input wire logic wb_stb_i, // Bus strobe
   input wire logic wb_we_i, // Bus write
   input wire logic [spoo_pkg::SPOO_ADR_W-1:0] wb_adr_i, // Bus address
   input wire logic [3:0] wb_sel_i, // Byte selects
   input wire logic [spoo_pkg::SPOO_DAT_W-1:0] wb_dat_i, // Write data
   input wire logic wb_ack_o, // Acknowledge
   input wire logic count_enable, // Count enable
   input wire logic u_pos_out, // U positive level
   input wire logic u_neg_out, // U negative level
   input wire logic v_pos_out, // V positive level
   input wire logic w_pos_out, // W positive level
   input wire logic w_neg_out, // W negative level
   input wire logic u_pos_oe // U positive enable
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] sw;
   logic [7:0] dead;
   logic [3:0] mode;
   logic oe_en;
   logic cnt;
   logic [8:0] quiet;
   wire take = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0];
   wire [5:0] a = wb_adr_i[7:2];
   wire act = mode[3];
   // Dead time may be up to 255, so settling is judged from the shadowed width
   wire settled = quiet > ({1'b0, dead} + 9'd8);
   // ----------------------------------------------------------------
   // Shadow of the writable fields
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         sw <= 8'h00;
         dead <= 8'h00;
         mode <= 4'h0;
         oe_en <= 1'b0;
         cnt <= 1'b0;
         quiet <= 9'h000;
      end else begin
         quiet <= (take || wb_sel_i[1]) && wb_cyc_i && wb_stb_i ? 9'h000 : quiet + {8'h00, quiet != 9'h1ff};
         if (take && a == SPOO_OFS_SW_PHASE[7:2]) sw <= wb_dat_i[7:0];
         if (take && a == SPOO_OFS_DEAD[7:2]) dead <= wb_dat_i[7:0];
         if (take && a == SPOO_OFS_MODE[7:2]) mode <= wb_dat_i[7:4];
         if (take && a == SPOO_OFS_OE[7:2]) oe_en <= wb_dat_i[0];
         if (wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[1] && a == SPOO_OFS_TCTL[7:2]) cnt <= wb_dat_i[15];
      end
   end
   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
   ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack");
   oe_gate_a: assert property (u_pos_oe == $past(oe_en && (sw[7] || cnt))) else $error("bad enable");
   cnt_en_a: assert property (count_enable == cnt) else $error("count enable wrong");
   sw_u_a: assert property (settled && sw[7] && u_pos_oe |-> u_pos_out == (sw[2] ? act : !act))
      else $error("U level wrong");
   sw_v_a: assert property (settled && sw[7] && u_pos_oe |-> v_pos_out == (sw[1] ? act : !act))
      else $error("V level wrong");
   sw_w_a: assert property (settled && sw[7] && u_pos_oe |-> w_pos_out == (sw[0] ? act : !act))
      else $error("W level wrong");
   pair_u_a: assert property (u_pos_oe && quiet > 9'd3 |->
      (mode[2] ? u_neg_out == u_pos_out : (u_neg_out != u_pos_out || u_pos_out == !act))) else $error("U pair");
   pair_w_a: assert property (u_pos_oe && quiet > 9'd3 |->
      (mode[0] ? w_neg_out == w_pos_out : (w_neg_out != w_pos_out || w_pos_out == !act))) else $error("W pair");
   cover property (take && a == SPOO_OFS_DEAD[7:2]);
   cover property (settled && sw[7] && u_pos_oe);
   cover property ($fell(u_pos_oe));
endmodule : spoo_chk

bind spoo_six_phase_output spoo_chk i_spoo_chk (.sys_clk(sys_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
   .wb_ack_o(wb_ack_o), .count_enable(count_enable), .u_pos_out(u_pos_out), .u_neg_out(u_neg_out),
   .v_pos_out(v_pos_out), .w_pos_out(w_pos_out), .w_neg_out(w_neg_out), .u_pos_oe(u_pos_oe));

// ### verification/spoo_gate_drv.sv
// Gate driver model: six driver inputs with pull-downs
module spoo_gate_drv
(
   input wire logic [5:0] lvl, // Pin levels from the stage
   input wire logic [5:0] oe, // Pin drive enables
   output logic [5:0] gate // Levels seen at the driver inputs
);
   timeunit 1ns;
   timeprecision 1ns;
   // Pull-downs keep the switches off while the stage floats the pins
   always_comb begin
      for (int i = 0; i < 6; i++) begin
         gate[i] = oe[i] ? lvl[i] : 1'b0;
      end
   end
endmodule : spoo_gate_drv

// ### verification/six_phase_output_override_test.sv
// Testbench: register and pin scenarios for the six-phase output stage
module six_phase_output_override_test;
   import spoo_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [3:0] sel = 4'h0;
   logic [31:0] wdat = 32'h0;
   logic [31:0] rdat;
   logic [31:0] rd;
   logic ack;
   logic cnt_en;
   logic [2:0] cset = 3'h0;
   logic [2:0] crst = 3'h0;
   wire [5:0] lvl;
   wire [5:0] oe;
   logic [5:0] gate;
   logic act = 1'b1;
   logic [2:0] pol = 3'h0;
   int errors = 0;
   int n_tests = 0;
   int cycles = 0;
   spoo_six_phase_output i_spoo_six_phase_output (.sys_clk(sys_clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .cmp_set(cset), .cmp_reset(crst), .count_enable(cnt_en), .u_pos_out(lvl[5]), .u_pos_oe(oe[5]),
      .u_neg_out(lvl[4]), .u_neg_oe(oe[4]), .v_pos_out(lvl[3]), .v_pos_oe(oe[3]), .v_neg_out(lvl[2]),
      .v_neg_oe(oe[2]), .w_pos_out(lvl[1]), .w_pos_oe(oe[1]), .w_neg_out(lvl[0]), .w_neg_oe(oe[0]));
   spoo_gate_drv i_spoo_gate_drv (.lvl(lvl), .oe(oe), .gate(gate));
   initial begin
      forever #50 sys_clk = ~sys_clk;
   end
   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task automatic end_sim;
      $display("Comparisons %0d, errors %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : end_sim
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         errors++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   // Classic cycle: hold the request until ack is sampled, then one idle cycle
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      sel <= s;
      // Look at ack mid-cycle where it is settled, then finish at the rising edge that samples it
      @(negedge sys_clk);
      while (ack !== 1'b1) @(negedge sys_clk);
      @(posedge sys_clk);
      rd = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      @(posedge sys_clk);
   endtask : wb
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      wb(1'b1, a, d, 4'h1);
   endtask : wr
   // Long enough for the dead-time window used here to close
   task automatic settle;
      repeat (14) @(posedge sys_clk);
   endtask : settle
   task automatic pulse(input logic [2:0] s, input logic [2:0] r);
      cset <= s;
      crst <= r;
      @(posedge sys_clk);
      cset <= 3'h0;
      crst <= 3'h0;
   endtask : pulse
   task automatic pins(input logic [2:0] v);
      logic p;
      for (int i = 0; i < 3; i++) begin
         p = v[2-i] ? act : !act;
         chk(gate[5-2*i], p);
         chk(gate[4-2*i], pol[2-i] ? p : !p);
      end
   endtask : pins
   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         errors++;
         end_sim();
      end
   end
   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   initial begin
      repeat (5) @(posedge sys_clk);
      rst_n <= 1'b1;
      @(posedge sys_clk);
      chk(oe, 6'h00);
      wb(1'b1, 8'h20, 32'hffffffff, 4'hf);
      // Status shows phase 0 pair levels with active level 0: positive pins 1 (inactive), negative pins 0 (active)
      for (int i = 0; i < 8; i++) begin
         wb(1'b0, 8'h20 - 8'(i * 4), 32'h0, 4'hf);
         chk(rd, ((8'h20 - 8'(i * 4)) == SPOO_OFS_STAT) ? 32'h15 : 32'h0);
      end
      wr(SPOO_OFS_SW_PHASE, 32'h84);
      settle;
      chk(oe, 6'h00);
      wr(SPOO_OFS_OE, 32'h1);
      settle;
      chk(oe, 6'h3f);
      for (int m = 0; m < 4; m++) begin
         act = m[0];
         pol = 3'(m * 3);
         wr(SPOO_OFS_MODE, {24'h0, act, pol, 4'h0});
         for (int v = 0; v < 8; v++) begin
            wr(SPOO_OFS_SW_PHASE, 32'h80 | v);
            settle;
            pins(v[2:0]);
         end
      end
      act = 1'b1;
      pol = 3'h0;
      wr(SPOO_OFS_MODE, 32'h80);
      wr(SPOO_OFS_DEAD, 32'h3);
      wr(SPOO_OFS_SW_PHASE, 32'h81);
      settle;
      wr(SPOO_OFS_SW_PHASE, 32'h80);
      @(posedge sys_clk);
      chk(gate[1:0], {!act, !act});
      settle;
      pins(3'h0);
      wr(SPOO_OFS_SW_PHASE, 32'h00);
      settle;
      chk(oe, 6'h00);
      wb(1'b1, SPOO_OFS_TCTL, 32'h8000, 4'h2);
      chk(cnt_en, 1'b1);
      settle;
      chk(oe, 6'h3f);
      wr(SPOO_OFS_SW_PHASE, 32'h84);
      settle;
      pulse(3'h0, 3'h4);
      settle;
      chk(gate[5], act);
      wr(SPOO_OFS_SW_PHASE, 32'h04);
      settle;
      chk(gate[5:4], {act, !act});
      pulse(3'h0, 3'h4);
      settle;
      chk(gate[5], !act);
      pulse(3'h4, 3'h0);
      settle;
      chk(gate[5], act);
      wr(SPOO_OFS_SW_PHASE, 32'h80);
      settle;
      chk(gate[5], !act);
      end_sim();
   end
endmodule : six_phase_output_override_test
